// >>> bench/card_control_monitor.sv
/* Concurrent checks on the card control block, top ports only.
   Assumes a bind from tb_top and the single pclk domain. */
`timescale 1ns/100ps
module card_control_monitor
  import card_control_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  card_ring_input,
  input wire logic        ring_indicate_output,
  input wire logic        ring_indicate_output_oe,
  input wire logic [1:0]  video_port_float_enable,
  input wire logic        speaker_output,
  input wire logic        speaker_output_oe,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic is_ctl = paddr == FUNC0_CTRL_ADDR || paddr == FUNC1_CTRL_ADDR;
  wire logic mapped = is_ctl || paddr == IRQ_STATUS_ADDR
                   || paddr == IRQ_MASK_ADDR || paddr == ROUTE_STATUS_ADDR;
  wire logic rd_done = pready && !pwrite;
  wire logic wr_acc = psel && penable && pwrite;
  //////////////////////////////////////////////////////////////////////////
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  error_unmapped_a: assert property (pready |-> pslverr == !mapped)
    else $error("slave error wrong");
  unmapped_zero_a: assert property (rd_done && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (
    rd_done && is_ctl |-> prdata[4:3] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("reserved bits not zero");
  ring_func1_a: assert property (
    rd_done && paddr == FUNC1_CTRL_ADDR |-> !prdata[BIT_RING])
    else $error("function 1 ring bit set");
  ring_gate_a: assert property (ring_indicate_output ==
    (ring_indicate_output_oe && |$past(card_ring_input)))
    else $error("ring output not gated");
  speaker_quiet_a: assert property (
    !speaker_output_oe |-> !speaker_output)
    else $error("speaker driven while off");
  float_by_write_a: assert property (
    $changed(video_port_float_enable) |-> $past(wr_acc, 2))
    else $error("float changed without write");
  spk_oe_write_a: assert property (
    $changed(speaker_output_oe) |-> $past(wr_acc, 2))
    else $error("speaker enable changed without write");
  cover property (wr_acc && pready);
  cover property (pslverr);
  cover property ($rose(irq));
  cover property (ring_indicate_output);
endmodule : card_control_monitor

// >>> bench/card_socket_model.sv
/* Two card sockets as seen from the controller pins.
   Assumes the bench asks for levels; the model registers them on pclk,
   so the controller never sees a change in the edge it was requested. */
`timescale 1ns/100ps
module card_socket_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] irq_req,
  input  wire logic [1:0] ring_req,
  input  wire logic [1:0] snd_req,
  input  wire logic [1:0] aud_req,
  output      logic [1:0] card_func_irq,
  output      logic [1:0] card_ring_input,
  output      logic [1:0] card_audio_signal,
  output      logic [1:0] card_speaker_input
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_func_irq <= 2'h0;
      card_ring_input <= 2'h0;
      card_audio_signal <= 2'h0;
      card_speaker_input <= 2'h0;
    end else begin
      card_func_irq <= irq_req;
      card_ring_input <= ring_req;
      card_audio_signal <= aud_req;
      card_speaker_input <= snd_req;
    end
  end
endmodule : card_socket_model

// >>> bench/tb_top.sv
/* Self-checking bench: APB master, socket model and reference values.
   Assumes the design answers APB without a wait state and registers pins. */
`timescale 1ns/100ps
module tb_top
  import card_control_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w0, w1, s;
  logic [3:0]  pstrb;
  logic [1:0]  card_func_irq, card_ring_input, card_audio_signal;
  logic [1:0]  card_speaker_input, video_port_float_enable;
  logic [1:0]  irq_req, ring_req, snd_req, aud_req;
  logic        ring_indicate_output, ring_indicate_output_oe, irq;
  logic        video_select_socket_a, video_select_socket_b;
  logic        card_audio_pulse_output, multifunction_pin_oe;
  logic        speaker_output, speaker_output_oe;
  logic [7:0]  f0, f1;
  int          seed = 10;
  int          bad_count = 0;
  int          checked = 0;
  card_control_register DUT (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .card_func_irq,
    .card_ring_input, .card_audio_signal, .card_speaker_input,
    .ring_indicate_output, .ring_indicate_output_oe, .video_port_float_enable,
    .video_select_socket_a, .video_select_socket_b, .card_audio_pulse_output,
    .multifunction_pin_oe, .speaker_output, .speaker_output_oe, .irq);
  card_socket_model sockets (.pclk, .presetn, .irq_req, .ring_req, .snd_req,
    .aud_req, .card_func_irq, .card_ring_input, .card_audio_signal,
    .card_speaker_input);
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_word
  task automatic cmp_pin(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_pin
  // Request held until pready is seen at an edge; only the watchdog ends it
  task automatic apb(logic [11:0] a, logic w, logic [31:0] d, logic [3:0] b);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= b;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_cmp(string n, logic [11:0] a, logic [31:0] e);
    apb(a, 1'b0, 32'h0, 4'hF);
    cmp_word(n, e, rd);
  endtask : rd_cmp
  //////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {irq_req, ring_req, snd_req, aud_req} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_cmp("f0 reset", FUNC0_CTRL_ADDR, 32'h0);
    rd_cmp("mask reset", IRQ_MASK_ADDR, 32'h0);
    for (int i = 0; i < 10; i++) begin
      w0 = $random(seed);
      w1 = $random(seed);
      s = $random(seed);
      {aud_req, ring_req, snd_req} <= s[5:0];
      apb(FUNC0_CTRL_ADDR, 1'b1, w0 & 32'hFFFF_FFFE, 4'hF);
      apb(FUNC1_CTRL_ADDR, 1'b1, w1 & 32'hFFFF_FFFE, 4'hF);
      f0 = w0[7:0] & 8'hE6;
      f1 = w1[7:0] & 8'h66;
      rd_cmp("f0", FUNC0_CTRL_ADDR, {24'h0, f0});
      rd_cmp("f1", FUNC1_CTRL_ADDR, {24'h0, f1});
      cmp_pin("ring oe", f0[7], ring_indicate_output_oe);
      cmp_pin("ring", f0[7] & |s[3:2], ring_indicate_output);
      cmp_pin("float", f0[6], video_port_float_enable[0]);
      cmp_pin("float1", f1[6], video_port_float_enable[1]);
      cmp_pin("mf oe", !f0[2] | !f1[2], multifunction_pin_oe);
      cmp_pin("spk oe", f0[1] | f1[1], speaker_output_oe);
      cmp_pin("spk", (f0[1] & s[0]) ^ (f1[1] & s[1]), speaker_output);
      if (!f0[2] || !f1[2])
        cmp_pin("audio", f0[2] ? s[5] : s[4], card_audio_pulse_output);
      if (f0[6] && f1[6]) begin
        cmp_pin("sel a", !f0[5], video_select_socket_a);
        cmp_pin("sel b", f0[5], video_select_socket_b);
      end
    end
    apb(FUNC0_CTRL_ADDR, 1'b1, 32'hFF, 4'hE);
    rd_cmp("no strobe", FUNC0_CTRL_ADDR, {24'h0, f0});
    apb(12'h100, 1'b1, w0, 4'hF);
    cmp_pin("unmapped err", 1'b1, er);
    irq_req <= 2'h2;
    repeat (2) @(posedge pclk);
    irq_req <= 2'h0;
    rd_cmp("f1 flag", FUNC1_CTRL_ADDR, {24'h0, f1 | 8'h01});
    rd_cmp("status", IRQ_STATUS_ADDR, 32'h2);
    cmp_pin("irq masked", 1'b0, irq);
    apb(IRQ_MASK_ADDR, 1'b1, 32'h2, 4'hF);
    repeat (2) @(posedge pclk);
    cmp_pin("irq", 1'b1, irq);
    apb(FUNC1_CTRL_ADDR, 1'b1, {24'h0, f1}, 4'hF);
    rd_cmp("f1 keep", FUNC1_CTRL_ADDR, {24'h0, f1 | 8'h01});
    apb(FUNC1_CTRL_ADDR, 1'b1, {24'h0, f1 | 8'h01}, 4'hF);
    rd_cmp("f1 clear", FUNC1_CTRL_ADDR, {24'h0, f1});
    apb(IRQ_STATUS_ADDR, 1'b1, 32'h2, 4'hF);
    rd_cmp("status clear", IRQ_STATUS_ADDR, 32'h0);
    cmp_pin("irq off", 1'b0, irq);
    // Socket 0 event seen only at the access edge of a clearing write
    fork
      apb(FUNC0_CTRL_ADDR, 1'b1, {24'h0, f0 | 8'h01}, 4'hF);
      begin
        @(posedge pclk);
        irq_req <= 2'h1;
        @(posedge pclk);
        irq_req <= 2'h0;
      end
    join
    rd_cmp("f0 set wins", FUNC0_CTRL_ADDR, {24'h0, f0 | 8'h01});
    rd_cmp("status set", IRQ_STATUS_ADDR, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_cmp("f0 rst", FUNC0_CTRL_ADDR, 32'h0);
    rd_cmp("f1 rst", FUNC1_CTRL_ADDR, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
bind card_control_register card_control_monitor mon (.pclk, .presetn,
  .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .card_ring_input, .ring_indicate_output, .ring_indicate_output_oe,
  .video_port_float_enable, .speaker_output, .speaker_output_oe, .irq);

// >>> design/card_control_func.sv
/*
  One function's card control byte. Function 0 carries the shared
  ring enable; the other function reads it as zero.
  Assumes wr_en is a one-cycle pulse at the APB access edge.
*/
`timescale 1ns/100ps
module card_control_func
  import card_control_pkg::*;
#(
  parameter bit HAS_RING = 1'b1
) (
  input  wire logic     pclk,
  input  wire logic     presetn,
  card_ctl_if.owner     ctl
);
  logic [7:0] bits_r;
  logic [7:0] bits_nxt;
  logic [7:0] wr_mask;
  logic       flag;

  // Only the global reset clears these [R11]
  assign wr_mask = {HAS_RING, 7'h67} & 8'hE6;            // [R2] [R10]
  assign bits_nxt = ctl.wr_en ? (ctl.wdata & wr_mask) : bits_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bits_r <= CTRL_RESET;                   // [R11]
    else          bits_r <= bits_nxt;
  end

  sticky_flag #(.W(1)) u_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (ctl.card_irq),                              // [R8]
    .clr     (ctl.wr_en & ctl.wdata[BIT_FLAG]),           // [R9] [R12]
    .flag    (flag)
  );

  assign ctl.value = {bits_r[7:1], flag};                 // [R10]
endmodule : card_control_func

// >>> design/card_control_pkg.sv
/*
  Constants shared by the card control register block: the APB map,
  the bit layout of the card control byte, reset values and the
  layout of the routing status word.
  Assumes a 32-bit APB with word-aligned registers, a 50 MHz pclk
  and presetn acting as the global reset of the controller.

  // How it works
  // R1: bit 7 set enables ring indicate output
  // R2: ring enable global, reached through function 0
  // R3: bit 6 floats that socket's video terminals
  // R4: bit 5 picks socket with video priority
  // R5: bit 2 zero routes card audio to pin
  // R6: bit 1 routes XOR of speaker inputs out
  // R7: speaker pin driven only while an enable set
  // R8: bit 0 set on socket functional interrupt
  // R9: software clears flag by writing one
  // R10: bits 4 and 3 always read zero
  // R11: reset value zero, cleared by global reset only
  // R12: writing zero keeps flag; set beats clear
*/
package card_control_pkg;

  // Printed offset is not word aligned: it is an index, byte address x4
  localparam logic [7:0]  CARD_CONTROL_IDX  = 8'h91;
  localparam logic [11:0] FUNC0_CTRL_ADDR   = {2'h0, CARD_CONTROL_IDX, 2'h0};
  localparam logic [11:0] FUNC1_CTRL_ADDR   = 12'h400 | FUNC0_CTRL_ADDR;
  localparam logic [11:0] IRQ_STATUS_ADDR   = 12'h800;
  localparam logic [11:0] IRQ_MASK_ADDR     = 12'h804;
  localparam logic [11:0] ROUTE_STATUS_ADDR = 12'h808;

  localparam int BIT_RING  = 7;
  localparam int BIT_FLOAT = 6;
  localparam int BIT_PRIO  = 5;
  localparam int BIT_AUDIO = 2;
  localparam int BIT_CARD_SPEAKER_INPUT  = 1;
  localparam int BIT_FLAG  = 0;

  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [5:0] ROUTE_RESET    = 6'h00;

  // Route status word layout
  localparam int RS_SEL_A   = 0;
  localparam int RS_SEL_B   = 1;
  localparam int RS_AUD_EN  = 2;
  localparam int RS_AUD_SRC = 3;
  localparam int RS_SPK_OE  = 4;
  localparam int RS_RING_OE = 5;

endpackage : card_control_pkg

// >>> design/card_control_register.sv
/*
  Card control register block for a two-socket card controller, with
  an APB slave, per-function control bytes, an interrupt status and
  mask pair, and the pin routing that the control bits steer.
  Assumes pins are synchronous to pclk, presetn is the global reset,
  and software reaches both functions at their own word addresses.
  Only byte lane 0 carries register data; a write with that lane off
  is dropped without an error, and the upper read bits are zero.
*/
`timescale 1ns/100ps
module card_control_register
  import card_control_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic [1:0]  card_func_irq,
  input  wire logic [1:0]  card_ring_input,
  input  wire logic [1:0]  card_audio_signal,
  input  wire logic [1:0]  card_speaker_input,
  output      logic        ring_indicate_output,
  output      logic        ring_indicate_output_oe,
  output      logic [1:0]  video_port_float_enable,
  output      logic        video_select_socket_a,
  output      logic        video_select_socket_b,
  output      logic        card_audio_pulse_output,
  output      logic        multifunction_pin_oe,
  output      logic        speaker_output,
  output      logic        speaker_output_oe,
  output      logic        irq
);

  //////////////////////////////////////////////////////////////////////
  // APB decode

  logic        setup_ph;
  logic        access_ph;
  logic        wr_fire;
  logic        hit_f0;
  logic        hit_f1;
  logic        hit_ist;
  logic        hit_imask;
  logic        hit_route;
  logic        hit_any;
  logic        lane0;

  logic        pready_r;
  logic        pready_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & pready_r;
  assign wr_fire   = access_ph & pwrite & hit_any;
  assign lane0     = pstrb[0];

  // Full 12-bit compare: no alias of a control byte is ever hit
  assign hit_f0    = (paddr == FUNC0_CTRL_ADDR);
  assign hit_f1    = (paddr == FUNC1_CTRL_ADDR);
  assign hit_ist   = (paddr == IRQ_STATUS_ADDR);
  assign hit_imask = (paddr == IRQ_MASK_ADDR);
  assign hit_route = (paddr == ROUTE_STATUS_ADDR);
  assign hit_any   = hit_f0 | hit_f1 | hit_ist | hit_imask | hit_route;

  // Write strobes per target. A write with byte lane 0 off is dropped
  // without an error, like a write to a read-only bit.
  logic wr_f0;
  logic wr_f1;
  logic wr_ist;
  logic wr_imask;

  assign wr_f0    = wr_fire & hit_f0 & lane0;
  assign wr_f1    = wr_fire & hit_f1 & lane0;
  assign wr_ist   = wr_fire & hit_ist & lane0;
  assign wr_imask = wr_fire & hit_imask & lane0;

  //////////////////////////////////////////////////////////////////////
  // Per-function control bytes

  // One carrier per function keeps strobe, data and flag together
  card_ctl_if f0_if ();
  card_ctl_if f1_if ();

  logic [7:0] f0_val;
  logic [7:0] f1_val;

  // Each function sees its own strobe and its own socket's interrupt
  assign f0_if.wr_en    = wr_f0;
  assign f0_if.wdata    = pwdata[7:0];
  assign f0_if.card_irq = card_func_irq[0];               // [R8]
  assign f1_if.wr_en    = wr_f1;
  assign f1_if.wdata    = pwdata[7:0];
  assign f1_if.card_irq = card_func_irq[1];               // [R8]

  // Ring enable is global: function 1 has no such bit [R2]
  card_control_func #(.HAS_RING(1'b1)) u_func0 (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (f0_if.owner)
  );

  card_control_func #(.HAS_RING(1'b0)) u_func1 (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (f1_if.owner)
  );

  assign f0_val = f0_if.value;
  assign f1_val = f1_if.value;

  //////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [1:0] ist_val;
  logic [1:0] ist_clr;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_mask_nxt;
  logic [1:0] irq_pend;
  logic       irq_r;
  logic       irq_nxt;

  // Write one to clear; a socket event in the same cycle still sets
  assign ist_clr = wr_ist ? pwdata[1:0] : 2'h0;

  sticky_flag #(.W(2)) u_ist (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (card_func_irq),
    .clr     (ist_clr),
    .flag    (ist_val)
  );

  // Masked sources still latch; unmasking later raises the line
  assign irq_mask_nxt = wr_imask ? pwdata[1:0] : irq_mask_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_mask_r <= IRQ_MASK_RESET;
    else          irq_mask_r <= irq_mask_nxt;
  end

  // Registered, so the line falls one cycle after the clearing write
  assign irq_pend = ist_val & irq_mask_r;
  assign irq_nxt  = |irq_pend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_r <= 1'b0;
    else          irq_r <= irq_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Ring indicate

  logic ring_en;
  logic ring_any;
  logic ring_nxt;
  logic ring_out_r;
  logic ring_oe_r;

  // Only function 0 holds the enable; function 1 reads it as zero
  assign ring_en  = f0_val[BIT_RING];                     // [R1] [R2]
  // Either socket ringing is enough to drive the shared pin
  assign ring_any = |card_ring_input;
  assign ring_nxt = ring_en & ring_any;                   // [R1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ring_out_r <= 1'b0;
    else          ring_out_r <= ring_nxt;
  end

  // Pin and enable move on the same edge: no stale level is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ring_oe_r <= ROUTE_RESET[RS_RING_OE];
    else          ring_oe_r <= ring_en;                   // [R1]
  end

  //////////////////////////////////////////////////////////////////////
  // Video port float and select priority

  logic       zv0;
  logic       zv1;
  logic       zv_prio1;
  logic       sel_a_nxt;
  logic       sel_b_nxt;
  logic [1:0] float_r;
  logic       sel_a_r;
  logic       sel_b_r;

  assign zv0      = f0_val[BIT_FLOAT];                    // [R3]
  assign zv1      = f1_val[BIT_FLOAT];                    // [R3]
  // Priority is a shared choice; function 0's copy decides. Function
  // 1's copy is stored and read back but steers nothing.
  assign zv_prio1 = f0_val[BIT_PRIO];

  // Priority only matters while both sockets are in video mode
  assign sel_a_nxt = zv0 & (~zv1 | ~zv_prio1);            // [R4]
  assign sel_b_nxt = zv1 & (~zv0 | zv_prio1);             // [R4]

  // Each socket floats on its own function's bit, whatever the other does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) float_r <= 2'h0;
    else          float_r <= {zv1, zv0};                  // [R3]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_a_r <= ROUTE_RESET[RS_SEL_A];
    else          sel_a_r <= sel_a_nxt;                   // [R4]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_b_r <= ROUTE_RESET[RS_SEL_B];
    else          sel_b_r <= sel_b_nxt;                   // [R4]
  end

  //////////////////////////////////////////////////////////////////////
  // Card audio to the multifunction pin

  logic aud_en0;
  logic aud_en1;
  logic aud_sel1;
  logic aud_nxt;
  logic aud_oe_nxt;
  logic aud_r;
  logic aud_oe_r;

  // Zero in the bit means routed; function 0 wins a tie
  assign aud_en0    = ~f0_val[BIT_AUDIO];                 // [R5]
  assign aud_en1    = ~f1_val[BIT_AUDIO];                 // [R5]
  // Socket 1 reaches the pin only when function 0 declines the route
  assign aud_sel1   = ~aud_en0 & aud_en1;
  assign aud_nxt    = aud_sel1 ? card_audio_signal[1]
                    : (aud_en0 & card_audio_signal[0]);   // [R5]
  // The pin is released when neither function routes audio
  assign aud_oe_nxt = aud_en0 | aud_en1;                  // [R5]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aud_r <= 1'b0;
    else          aud_r <= aud_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) aud_oe_r <= ROUTE_RESET[RS_AUD_EN];
    else          aud_oe_r <= aud_oe_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Speaker

  logic spk_en0;
  logic spk_en1;
  logic spk_nxt;
  logic spk_oe_nxt;
  logic spk_r;
  logic spk_oe_r;

  assign spk_en0 = f0_val[BIT_CARD_SPEAKER_INPUT];
  assign spk_en1 = f1_val[BIT_CARD_SPEAKER_INPUT];
  // A disabled socket contributes a zero to the XOR
  assign spk_nxt = (spk_en0 & card_speaker_input[0])
                 ^ (spk_en1 & card_speaker_input[1]);     // [R6]
  assign spk_oe_nxt = spk_en0 | spk_en1;                  // [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spk_r <= 1'b0;
    else          spk_r <= spk_nxt;                       // [R6]
  end

  // Driven while either function enables it; the pin floats otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spk_oe_r <= ROUTE_RESET[RS_SPK_OE];
    else          spk_oe_r <= spk_oe_nxt;                 // [R7]
  end

  //////////////////////////////////////////////////////////////////////
  // Read mux and APB answer

  logic [5:0] route_val;
  logic [7:0] rd_byte;

  always_comb begin
    route_val             = ROUTE_RESET;
    route_val[RS_SEL_A]   = sel_a_r;
    route_val[RS_SEL_B]   = sel_b_r;
    route_val[RS_AUD_EN]  = aud_oe_r;
    // Also set while nothing is routed; read it with the enable bit
    route_val[RS_AUD_SRC] = ~aud_en0;
    route_val[RS_SPK_OE]  = spk_oe_r;
    route_val[RS_RING_OE] = ring_oe_r;
  end

  // Unmapped addresses read zero and answer with an error
  assign rd_byte = hit_f0    ? f0_val
                 : hit_f1    ? f1_val
                 : hit_ist   ? {6'h00, ist_val}
                 : hit_imask ? {6'h00, irq_mask_r}
                 : hit_route ? {2'h0, route_val}
                 : 8'h00;

  // No wait state: data is captured in the setup cycle, so a read
  // shows the state at the end of that cycle
  assign pready_nxt  = setup_ph;
  assign prdata_nxt  = setup_ph ? {24'h000000, rd_byte} : prdata_r;
  assign pslverr_nxt = setup_ph & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pready_r <= 1'b0;
    else          pready_r <= pready_nxt;
  end

  // Read data holds until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h00000000;
    else          prdata_r <= prdata_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pslverr_r <= 1'b0;
    else          pslverr_r <= pslverr_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs

  // Every pin comes straight from a flip-flop above
  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign ring_indicate_output    = ring_out_r;
  assign ring_indicate_output_oe = ring_oe_r;
  assign video_port_float_enable = float_r;
  assign video_select_socket_a   = sel_a_r;
  assign video_select_socket_b   = sel_b_r;
  assign card_audio_pulse_output = aud_r;
  assign multifunction_pin_oe    = aud_oe_r;
  assign speaker_output          = spk_r;
  assign speaker_output_oe       = spk_oe_r;
  assign irq                     = irq_r;

endmodule : card_control_register

// >>> design/card_ctl_if.sv
/*
  Carrier between the top block and one per-function card control
  byte: write strobe and data in, card interrupt in, byte value out.
  Assumes a single pclk domain.
*/
`timescale 1ns/100ps
interface card_ctl_if;
  logic       wr_en;
  logic [7:0] wdata;
  logic       card_irq;
  logic [7:0] value;

  modport owner (input wr_en, input wdata, input card_irq, output value);
  modport user  (output wr_en, output wdata, output card_irq, input value);
endinterface : card_ctl_if

// >>> design/sticky_flag.sv
/*
  Sticky flags, set by hardware and cleared by writing one.
  Assumes set and clear are single-cycle qualified in pclk.
*/
`timescale 1ns/100ps
module sticky_flag #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output      logic [W-1:0] flag
);
  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  // A set in the clearing cycle survives [R12]
  assign flag_nxt = (flag_r & ~clr) | set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_r <= '0;
    else          flag_r <= flag_nxt;
  end

  assign flag = flag_r;
endmodule : sticky_flag
